// >>> common/fic_pkg.sv
// Constants shared by the interrupt controller design files.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz system clock.
package fic_pkg;

    // Source lines: 0-7 external, 8-9 reserved, 10-19 peripherals, 20 software
    localparam int NUM_LINES = 25;
    localparam int NUM_EXT = 8;
    localparam int NUM_RSVD_LO = 2;
    localparam int NUM_PERIPH = 10;
    localparam int NUM_RSVD_HI = 4;
    localparam int SW_LINE = 20;

    // Bus widths and responses
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register offsets, relative to the region that holds the block
    localparam logic [ADDR_W-1:0] REGION_BASE = 32'h0900_0000;
    localparam logic [15:0] OFF_GLOBAL_MASK = 16'h1200;
    localparam logic [15:0] OFF_TRIG_MODE = 16'h1204;
    localparam logic [15:0] OFF_TRIG_POL = 16'h1208;
    localparam logic [15:0] OFF_ROUTING = 16'h120c;
    localparam logic [15:0] OFF_FAST_STATUS = 16'h1210;
    localparam logic [15:0] OFF_NORM_STATUS = 16'h1214;
    localparam logic [15:0] OFF_FAST_MASK = 16'h1218;
    localparam logic [15:0] OFF_NORM_MASK = 16'h121c;
    localparam logic [15:0] OFF_PEND_CLEAR = 16'h1220;
    localparam logic [15:0] OFF_SOFT_REQ = 16'h1224;
    localparam logic [15:0] OFF_EVT_STATUS = 16'h1228;
    localparam logic [15:0] OFF_EVT_MASK = 16'h122c;

    // Reset values and the software line bit
    localparam logic [NUM_LINES-1:0] TRIG_MODE_RST = 25'h000_0000;
    localparam logic [NUM_LINES-1:0] TRIG_POL_RST = 25'h100_0000;
    localparam logic [NUM_LINES-1:0] LINE_ZERO = 25'h000_0000;
    localparam logic [NUM_LINES-1:0] SW_LINE_BIT = 25'h010_0000;

    // Field positions of the single-bit control registers and the two-bit event registers
    localparam int GMASK_DIS_BIT = 0;
    localparam int SOFT_REQ_BIT = 0;
    localparam int EVT_W = 2;
    localparam int EVT_FAST_BIT = 0;
    localparam int EVT_NORM_BIT = 1;
    localparam logic [EVT_W-1:0] EVT_ZERO = 2'h0;

endpackage : fic_pkg

// >>> hw/fic_line_detect.sv
// One source line: optional two-stage synchroniser, edge and level detection.
// Assumes polarity comes from a register on sys_clk.
module fic_line_detect
    import fic_pkg::*;
#(
    parameter bit SYNC = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic srcIn,
    input wire logic polarity,
    output logic edgeEvt_ff,
    output logic levelAct_ff
);

    logic sampled;
    logic prev_ff;

    // Pins pass two flip-flops; same-clock sources are used as they are
    generate
        if (SYNC) begin : g_sync
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= srcIn;
                    sync_ff <= meta_ff;
                end
            end
            assign sampled = sync_ff;
        end else begin : g_direct
            assign sampled = srcIn;
        end
    endgenerate

    // Previous sample for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sampled;
        end
    end

    // Raw edges are compared, so a polarity change alone makes no event
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeEvt_ff <= 1'b0;
            levelAct_ff <= 1'b0;
        end else begin
            edgeEvt_ff <= polarity ? (sampled & ~prev_ff) : (~sampled & prev_ff); // RULE_05
            levelAct_ff <= polarity ? sampled : ~sampled; // RULE_05
        end
    end

endmodule // fic_line_detect

// >>> hw/fic_pend_bank.sv
// A bank of pending status bits, one per line.
// Edge lines are sticky until cleared; level lines follow the source.
module fic_pend_bank
    import fic_pkg::*;
#(
    parameter int W = NUM_LINES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] setEvt,
    input wire logic [W-1:0] levelAct,
    input wire logic [W-1:0] levelMode,
    input wire logic [W-1:0] clrBits,
    output logic [W-1:0] pend_ff
);

    logic [W-1:0] nxt_pend;

    // Set wins over a clear in the same cycle; clears only touch edge lines
    always_comb begin
        nxt_pend = (levelMode & levelAct) // RULE_12
                 | (~levelMode & ((pend_ff & ~clrBits) | setEvt)); // RULE_10 RULE_11
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

endmodule // fic_pend_bank

// >>> hw/fic_ctrl.sv
// Interrupt controller top: AXI4-Lite register slave, 25 source lines,
// fast and normal request outputs and a controller event interrupt.
// Assumes peripheral sources run on sys_clk and external pins are async.

// Functional notes
// RULE_01: lines 0-7 external, 10-19 peripherals, 20 software
// RULE_02: every line defaults to falling edge detection; line 24 resets to rising edge and line 20 is forced to high level
// RULE_03: no hardware priority and no vectors
// RULE_04: mask bit one blocks, zero passes
// RULE_05: mode and polarity pair select detection
// RULE_06: polarity register resets to 0x01000000
// RULE_07: routing one is fast, zero normal
// RULE_08: fast-routed activity sets fast pending bit
// RULE_09: normal-routed activity sets normal pending bit
// RULE_10: write one clears pending, edge lines only
// RULE_11: zero bits in clear write change nothing
// RULE_12: clear writes ignored for level lines
// RULE_13: fast mask blocks fast request, resets zero
// RULE_14: normal mask blocks normal request, resets zero
// RULE_15: line 20 software source, high level
// RULE_16: software masks unimplemented lines
// RULE_17: registers decoded from base 0x0900_1200
// RULE_18: outputs follow unmasked pending bits
// RULE_19: global mask bit disables both outputs
module fic_ctrl
    import fic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_EXT-1:0] extReq,
    input wire logic [NUM_PERIPH-1:0] periphReq,
    output logic fastReq_ff,
    output logic normalReq_ff,
    output logic evtIrq_ff
);

    localparam int PAD_W = DATA_W - NUM_LINES;
    localparam int OFF_W = $bits(OFF_GLOBAL_MASK);

    // Write and read channel holding registers
    logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [DATA_W-1:0] wData_ff, rdata_ff;
    logic [STRB_W-1:0] wStrb_ff;
    logic [1:0] bresp_ff, rresp_ff;

    // Configuration and state registers
    logic globalDis_ff, softReq_ff, fastPrev_ff, normPrev_ff;
    logic [NUM_LINES-1:0] trigMode_ff, trigPol_ff, route_ff, fastMask_ff, normMask_ff;
    logic [EVT_W-1:0] evtStatus_ff, evtMask_ff;

    // Combinational bus terms
    logic awTake, wTake, wrFire, wrGo, wrHit, rdFire, rdHit, rdErr, wrErr;
    logic [ADDR_W-1:0] wrAddr;
    logic [OFF_W-1:0] wrOff, rdOff;
    logic [DATA_W-1:0] wrData, wrMask, rdMux;
    logic [STRB_W-1:0] wrStrb;
    logic [NUM_LINES-1:0] lineMask, lineData;
    logic weGlobal, weMode, wePol, weRoute, weFastMask, weNormMask, weClear, weSoft, weEvtMask;

    // Detection and pending terms
    logic [NUM_LINES-1:0] rawSrc, effMode, effPol, edgeEvt;
    logic [NUM_LINES-1:0] levelAct, clrBits, fastPend, normPend;
    logic nxt_fastReq, nxt_normalReq;
    logic [EVT_W-1:0] evtSet;

    // A channel is ready while nothing is held and no response is waiting
    assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
    assign s_axi_wready = ~wHeld_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    assign awTake = s_axi_awvalid & s_axi_awready;
    assign wTake = s_axi_wvalid & s_axi_wready;
    assign rdFire = s_axi_arvalid & s_axi_arready;
    // The write happens the cycle both halves are present, held or arriving
    assign wrFire = (awHeld_ff | awTake) & (wHeld_ff | wTake);
    assign wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
    assign wrData = wHeld_ff ? wData_ff : s_axi_wdata;
    assign wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
    assign wrGo = wrFire & wrHit;
    // Upper half checks the region, lower half picks the register
    assign wrHit = wrAddr[ADDR_W-1:OFF_W] == REGION_BASE[ADDR_W-1:OFF_W]; // RULE_17
    assign rdHit = s_axi_araddr[ADDR_W-1:OFF_W] == REGION_BASE[ADDR_W-1:OFF_W]; // RULE_17
    assign wrOff = {wrAddr[OFF_W-1:2], 2'h0};
    assign rdOff = {s_axi_araddr[OFF_W-1:2], 2'h0};
    assign lineMask = wrMask[NUM_LINES-1:0];
    assign lineData = wrData[NUM_LINES-1:0] & lineMask;

    // Byte strobes expanded to a bit mask
    always_comb begin
        for (int b = 0; b < STRB_W; b++) begin
            wrMask[b*8 +: 8] = {8{wrStrb[b]}};
        end
    end

    // Address and data halves are taken in either order
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (wrFire) begin
            awHeld_ff <= 1'b0;
        end else if (awTake) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_ff <= 1'b0;
            wData_ff <= '0;
            wStrb_ff <= '0;
        end else if (wrFire) begin
            wHeld_ff <= 1'b0;
        end else if (wTake) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end
    end

    // Write decode on the full byte address, low two bits ignored
    always_comb begin
        weGlobal = 1'b0;
        weMode = 1'b0;
        wePol = 1'b0;
        weRoute = 1'b0;
        weFastMask = 1'b0;
        weNormMask = 1'b0;
        weClear = 1'b0;
        weSoft = 1'b0;
        weEvtMask = 1'b0;
        wrErr = 1'b0;
        unique case (wrOff)
            OFF_GLOBAL_MASK: weGlobal = wrGo; // RULE_17
            OFF_TRIG_MODE: weMode = wrGo;
            OFF_TRIG_POL: wePol = wrGo;
            OFF_ROUTING: weRoute = wrGo;
            OFF_FAST_MASK: weFastMask = wrGo;
            OFF_NORM_MASK: weNormMask = wrGo;
            OFF_PEND_CLEAR: weClear = wrGo;
            OFF_SOFT_REQ: weSoft = wrGo;
            OFF_EVT_MASK: weEvtMask = wrGo;
            // Status registers are read-only: writes are dropped quietly
            OFF_FAST_STATUS: wrErr = 1'b0;
            OFF_NORM_STATUS: wrErr = 1'b0;
            OFF_EVT_STATUS: wrErr = 1'b0;
            default: wrErr = 1'b1;
        endcase
        wrErr = wrErr | ~wrHit;
    end

    // Write response, one cycle after the write is performed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wrErr ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Byte-enabled configuration writes; every bit resets to a known value
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trigMode_ff <= TRIG_MODE_RST; // RULE_02
            trigPol_ff <= TRIG_POL_RST; // RULE_06
            route_ff <= LINE_ZERO; // RULE_07
        end else begin
            if (weMode) begin
                trigMode_ff <= (trigMode_ff & ~lineMask) | lineData;
            end
            if (wePol) begin
                trigPol_ff <= (trigPol_ff & ~lineMask) | lineData;
            end
            if (weRoute) begin
                route_ff <= (route_ff & ~lineMask) | lineData;
            end
        end
    end

    // Request masks, global disable and software source
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastMask_ff <= LINE_ZERO; // RULE_13
            normMask_ff <= LINE_ZERO; // RULE_14
            globalDis_ff <= 1'b0;
            softReq_ff <= 1'b0;
        end else begin
            if (weFastMask) begin
                fastMask_ff <= (fastMask_ff & ~lineMask) | lineData;
            end
            if (weNormMask) begin
                normMask_ff <= (normMask_ff & ~lineMask) | lineData;
            end
            if (weGlobal && wrMask[GMASK_DIS_BIT]) begin
                globalDis_ff <= wrData[GMASK_DIS_BIT]; // RULE_19
            end
            if (weSoft && wrMask[SOFT_REQ_BIT]) begin
                softReq_ff <= wrData[SOFT_REQ_BIT]; // RULE_15
            end
        end
    end

    // Clear pulse: only written one bits in enabled byte lanes take effect
    assign clrBits = weClear ? lineData : LINE_ZERO; // RULE_10 RULE_11

    // Read mux; the clear register reads as zero
    always_comb begin
        rdMux = '0;
        rdErr = 1'b0;
        unique case (rdOff)
            OFF_GLOBAL_MASK: rdMux[GMASK_DIS_BIT] = globalDis_ff;
            OFF_TRIG_MODE: rdMux = {{PAD_W{1'b0}}, trigMode_ff};
            OFF_TRIG_POL: rdMux = {{PAD_W{1'b0}}, trigPol_ff};
            OFF_ROUTING: rdMux = {{PAD_W{1'b0}}, route_ff};
            OFF_FAST_STATUS: rdMux = {{PAD_W{1'b0}}, fastPend}; // RULE_08
            OFF_NORM_STATUS: rdMux = {{PAD_W{1'b0}}, normPend}; // RULE_09
            OFF_FAST_MASK: rdMux = {{PAD_W{1'b0}}, fastMask_ff};
            OFF_NORM_MASK: rdMux = {{PAD_W{1'b0}}, normMask_ff};
            OFF_PEND_CLEAR: rdMux = '0;
            OFF_SOFT_REQ: rdMux[SOFT_REQ_BIT] = softReq_ff;
            OFF_EVT_STATUS: rdMux[EVT_W-1:0] = evtStatus_ff;
            OFF_EVT_MASK: rdMux[EVT_W-1:0] = evtMask_ff;
            default: rdErr = 1'b1;
        endcase
        // Outside the region nothing answers with data
        if (!rdHit) begin
            rdMux = '0;
            rdErr = 1'b1;
        end
    end

    // Read data is captured at the address handshake, answered next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (rdFire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rdMux;
            rresp_ff <= rdErr ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Source vector; reserved lines are tied low and must be masked by software
    assign rawSrc = {{NUM_RSVD_HI{1'b0}}, softReq_ff, periphReq,
                     {NUM_RSVD_LO{1'b0}}, extReq}; // RULE_01 RULE_16

    // Line 20 is forced to high level regardless of its configuration bits
    assign effMode = trigMode_ff | SW_LINE_BIT; // RULE_15
    assign effPol = trigPol_ff | SW_LINE_BIT; // RULE_15

    // One detector per line; only the external pins are synchronised
    generate
        for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
            fic_line_detect #(
                .SYNC(i < NUM_EXT)
            ) u_detect (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .srcIn(rawSrc[i]),
                .polarity(effPol[i]),
                .edgeEvt_ff(edgeEvt[i]),
                .levelAct_ff(levelAct[i])
            );
        end
    endgenerate

    // Routing splits each line's activity into one of the two status banks
    fic_pend_bank #(
        .W(NUM_LINES)
    ) u_fast_bank (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .setEvt(edgeEvt & route_ff), // RULE_07 RULE_08
        .levelAct(levelAct & route_ff),
        .levelMode(effMode),
        .clrBits(clrBits),
        .pend_ff(fastPend)
    );

    fic_pend_bank #(
        .W(NUM_LINES)
    ) u_norm_bank (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .setEvt(edgeEvt & ~route_ff), // RULE_07 RULE_09
        .levelAct(levelAct & ~route_ff),
        .levelMode(effMode),
        .clrBits(clrBits),
        .pend_ff(normPend)
    );

    // Plain OR of unmasked bits: software sorts priority by reading status
    assign nxt_fastReq = ~globalDis_ff & |(fastPend & ~fastMask_ff); // RULE_03 RULE_04 RULE_18
    assign nxt_normalReq = ~globalDis_ff & |(normPend & ~normMask_ff); // RULE_04 RULE_18

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastReq_ff <= 1'b0;
            normalReq_ff <= 1'b0;
            fastPrev_ff <= 1'b0;
            normPrev_ff <= 1'b0;
        end else begin
            fastReq_ff <= nxt_fastReq; // RULE_13
            normalReq_ff <= nxt_normalReq; // RULE_14
            fastPrev_ff <= fastReq_ff;
            normPrev_ff <= normalReq_ff;
        end
    end

    // Controller events: a request output rising
    assign evtSet[EVT_FAST_BIT] = fastReq_ff & ~fastPrev_ff;
    assign evtSet[EVT_NORM_BIT] = normalReq_ff & ~normPrev_ff;

    // Sticky event bits clear on read; a new event in that cycle survives
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtStatus_ff <= EVT_ZERO;
            evtMask_ff <= EVT_ZERO;
        end else begin
            if (rdFire && !rdErr && rdOff == OFF_EVT_STATUS) begin
                evtStatus_ff <= evtSet;
            end else begin
                evtStatus_ff <= evtStatus_ff | evtSet;
            end
            if (weEvtMask && wrMask[0]) begin
                evtMask_ff <= wrData[EVT_W-1:0];
            end
        end
    end

    // Level interrupt while any enabled event bit is set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtIrq_ff <= 1'b0;
        end else begin
            evtIrq_ff <= |(evtStatus_ff & evtMask_ff);
        end
    end

endmodule // fic_ctrl

// >>> test/fic_ctrl_chk.sv
// Port checker for fic_ctrl: bus answers and request outputs.
// Assumes a bind to fic_ctrl; inputs carry its port names.
module fic_ctrl_chk
    import fic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fastReq_ff,
    input wire logic normalReq_ff,
    input wire logic evtIrq_ff
);
    // One domain, so clock and reset are stated once
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // A write takes two steps: both halves taken, then the answer
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_ans;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_wr_ans; s_wr_both |=> s_wr_ans; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_end: assert property (p_b_end) else $error("write answer stuck");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_end: assert property (p_r_end) else $error("read answer stuck");
    // An error answer never carries data
    property p_resp;
        s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0);
    endproperty
    a_resp: assert property (p_resp) else $error("bad read answer");
    property p_rst_out; $rose(rst_n) |-> !fastReq_ff && !normalReq_ff && !evtIrq_ff; endproperty
    a_rst_out: assert property (p_rst_out) else $error("request out of reset");
endmodule // fic_ctrl_chk

bind fic_ctrl fic_ctrl_chk i_chk (.*);

// >>> test/fic_core_model.sv
// Core-side model: takes each new fast and normal request once.
// Assumes level requests clocked by sys_clk.
module fic_core_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fastReq,
    input wire logic normalReq,
    output logic [7:0] fiqCount_ff,
    output logic [7:0] irqCount_ff
);
    logic [1:0] lastReq_ff;
    // A held level is one request; only a rise is a new one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastReq_ff <= 2'h0;
            fiqCount_ff <= 8'h0;
            irqCount_ff <= 8'h0;
        end else begin
            lastReq_ff <= {fastReq, normalReq};
            fiqCount_ff <= fiqCount_ff + 8'(fastReq && !lastReq_ff[1]);
            irqCount_ff <= irqCount_ff + 8'(normalReq && !lastReq_ff[0]);
        end
    end
endmodule // fic_core_model

// >>> test/fic_ctrl_tb.sv
// Bench for fic_ctrl: register map, detection modes, routing, masks, events.
// Assumes the bound checker and fic_core_model at the core side.
module fic_ctrl_tb
    import fic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic [7:0] extReq = 8'hff;
    logic [9:0] periphReq = 10'h3ff;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic fastReq_ff, normalReq_ff, evtIrq_ff;
    logic [7:0] fiqCount;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    fic_ctrl i_dut (.*);
    // Core model takes requests as a processor would
    fic_core_model i_core (.sys_clk(sys_clk), .rst_n(rst_n), .fastReq(fastReq_ff),
        .normalReq(normalReq_ff), .fiqCount_ff(fiqCount), .irqCount_ff());

    // Clock, 100 ns period
    initial forever #50 sys_clk = ~sys_clk;

    // Guard against a hung handshake
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Handshakes are taken at rising edges; each channel drops when taken
    task automatic wr(input logic [15:0] o, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        s_axi_awaddr <= REGION_BASE + 32'(o);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge sys_clk); while (!s_axi_bvalid);
        chk("bresp", 32'(s_axi_bresp), 32'(r));
    endtask

    task automatic rd(input logic [15:0] o, input logic [31:0] e,
        input logic [1:0] r = RESP_OKAY);
        s_axi_araddr <= REGION_BASE + 32'(o);
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        chk($sformatf("reg %h", o), s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask

    // Outputs are given time to settle: fast, normal, event
    task automatic rq(input logic [2:0] e);
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("fast norm evt", 32'({fastReq_ff, normalReq_ff, evtIrq_ff}), 32'(e));
        @(posedge sys_clk);
    endtask

    task automatic pulse(input int b);
        periphReq[b] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        periphReq[b] <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int k = 0; k < 9; k++) begin
            rd(16'h1200 + 16'(4 * k), k == 2 ? 32'h0100_0000 : 32'h0);
        end
        rd(16'h1300, 32'h0, RESP_SLVERR);
        wr(16'h1300, 32'h1, RESP_SLVERR);
        wr(OFF_FAST_MASK, 32'h01e0_0300);
        wr(OFF_NORM_MASK, 32'h01e0_0300);
        rd(OFF_NORM_MASK, 32'h01e0_0300);
        // Default falling edge on line 10 pends in the normal bank
        pulse(0);
        rd(OFF_NORM_STATUS, 32'h400);
        rd(OFF_FAST_STATUS, 32'h0);
        rq(3'b010);
        wr(OFF_PEND_CLEAR, 32'h0);
        rd(OFF_NORM_STATUS, 32'h400);
        wr(OFF_PEND_CLEAR, 32'h400);
        rd(OFF_NORM_STATUS, 32'h0);
        rq(3'b000);
        // Line 11 routed fast, then masked, then globally disabled
        wr(OFF_ROUTING, 32'h800);
        pulse(1);
        rd(OFF_FAST_STATUS, 32'h800);
        rq(3'b100);
        wr(OFF_FAST_MASK, 32'h01e0_0b00);
        rq(3'b000);
        rd(OFF_FAST_STATUS, 32'h800);
        wr(OFF_FAST_MASK, 32'h01e0_0300);
        wr(OFF_GLOBAL_MASK, 32'h1);
        rq(3'b000);
        wr(OFF_GLOBAL_MASK, 32'h0);
        rq(3'b100);
        wr(OFF_PEND_CLEAR, 32'h800);
        chk("fiq count", 32'(fiqCount), 32'h3);
        wr(OFF_EVT_MASK, 32'h2);
        rd(OFF_EVT_STATUS, 32'h3);
        // Every mode and polarity pair on line 12; level lines ignore clears
        for (int m = 0; m < 4; m++) begin
            wr(OFF_TRIG_MODE, 32'(m[1]) << 12);
            wr(OFF_TRIG_POL, 32'h0100_0000 | (32'(m[0]) << 12));
            periphReq[2] <= !m[0];
            repeat (5) @(posedge sys_clk);
            wr(OFF_PEND_CLEAR, 32'h1000);
            rd(OFF_NORM_STATUS, 32'h0);
            periphReq[2] <= m[0];
            repeat (5) @(posedge sys_clk);
            rd(OFF_NORM_STATUS, 32'h1000);
            wr(OFF_PEND_CLEAR, 32'h1000);
            rd(OFF_NORM_STATUS, m[1] ? 32'h1000 : 32'h0);
        end
        wr(OFF_TRIG_MODE, 32'h0);
        wr(OFF_TRIG_POL, 32'h0100_0000);
        wr(OFF_PEND_CLEAR, 32'h1000);
        rd(OFF_EVT_STATUS, 32'h2);
        // Software line 20 is a high level held by its control bit
        wr(OFF_SOFT_REQ, 32'h1);
        rq(3'b011);
        wr(OFF_PEND_CLEAR, 32'h10_0000);
        wr(OFF_NORM_STATUS, 32'hffff_ffff);
        rd(OFF_NORM_STATUS, 32'h10_0000);
        rd(OFF_EVT_STATUS, 32'h2);
        wr(OFF_SOFT_REQ, 32'h0);
        rq(3'b000);
        // External pin 7 goes through the synchroniser first
        extReq <= 8'h7f;
        repeat (2) @(posedge sys_clk);
        extReq <= 8'hff;
        repeat (8) @(posedge sys_clk);
        rd(OFF_NORM_STATUS, 32'h80);
        tally_and_finish();
    end
endmodule // fic_ctrl_tb
